// [alarm_logic_evaluator.sv]
`timescale 1ns/1ps

// Functional notes
// - Without alarm reset, the action drops as soon as its condition clears.
// - With alarm reset, the action latches until an explicit reset arrives.
// - Reset sources: front display, digital input, a logic state, bus command.
// - Delayed signal follows Z after switch-in or dropout delay.
// - Action state equals function output, complemented when inversion is set.
// - Two-level gate network; gates AND, OR, XOR, NAND, NOR, XNOR.
// - AND all used true, OR any true; NAND, NOR are complements.
// - XOR true only when exactly one used input is true.
// - XNOR true when used inputs are all true or all false.
// - First-level gates take up to three inputs, second-level up to four.
// - Unused gate inputs are neutral and do not affect the result.
// - ON threshold above OFF threshold makes an upper limit.
// - Upper limit sets above ON, clears below OFF, else holds.
// - Lower limit sets below ON, clears above OFF, else holds.
// - Equal thresholds behave as upper limit with zero hysteresis.
// - Hour counter advances only while its limit is true.
// - Each pass computes Y, then Z, then D, then A outputs.
// - One pass per line cycle; never more than 25 ms apart.
// - Z, D and A states used as inputs act only in the next pass.
// - Earlier first-level outputs feed later first-level gates in the pass.
module alarm_logic_evaluator #(
  parameter int unsigned PASS_MAX_CYC = alarm_pkg::PASS_MAX_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire alarm_pkg::axi_req_t s_axi_req,
  output alarm_pkg::axi_rsp_t s_axi_rsp,
  input wire alarm_pkg::meas_t meas,
  input wire logic cycle_tick,
  input wire logic panel_reset,
  input wire logic din,
  output logic [3:0] action
);

  // Gate result; no used input yields false
  function automatic logic gate_eval(input alarm_pkg::gate_cfg_t c,
                                     input logic [31:0] pool,
                                     input logic [3:0] lvl_mask);
    logic [3:0] used;
    logic [3:0] hit;
    logic [2:0] n;
    logic [2:0] m;
    logic r;
    used = c.en & lvl_mask;
    hit = used & {pool[c.sel3], pool[c.sel2], pool[c.sel1], pool[c.sel0]};
    n = {2'h0, hit[0]} + {2'h0, hit[1]} + {2'h0, hit[2]} + {2'h0, hit[3]};
    m = {2'h0, used[0]} + {2'h0, used[1]} + {2'h0, used[2]}
        + {2'h0, used[3]};
    unique case (c.op)
      alarm_pkg::G_AND: r = (n == m);
      alarm_pkg::G_OR: r = (n != 3'h0);
      alarm_pkg::G_XOR: r = (n == 3'h1);
      alarm_pkg::G_NAND: r = (n != m);
      alarm_pkg::G_NOR: r = (n == 3'h0);
      alarm_pkg::G_XNOR: r = (n == 3'h0) || (n == m);
      default: r = 1'b0;
    endcase
    gate_eval = (used != 4'h0) & r;
  endfunction : gate_eval

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (data & m);
  endfunction : merge

  alarm_pkg::axi_rsp_t rsp_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [alarm_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  alarm_pkg::limit_cfg_t lim_cfg_q [4];
  alarm_pkg::gate_cfg_t gate_q [8];
  alarm_pkg::func_cfg_t func_q [4];
  logic [31:0] hours_q [4];
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  alarm_pkg::pass_st_t st_q;
  logic [1:0] idx_q;
  logic [alarm_pkg::WD_W-1:0] wd_q;
  logic [3:0] lim_q;
  logic [3:0] y_q;
  logic [3:0] z_q;
  logic [3:0] d_q;
  logic [3:0] a_q;
  logic [3:0] act_q;
  logic [15:0] snap_q;
  logic [7:0] cnt_q [4];
  logic [3:0] rst_pend_q;

  // Bus handshakes
  wire aw_take = s_axi_req.awvalid & rsp_q.awready;
  wire w_take = s_axi_req.wvalid & rsp_q.wready;
  wire b_done = rsp_q.bvalid & s_axi_req.bready;
  wire ar_take = s_axi_req.arvalid & rsp_q.arready;
  wire r_done = rsp_q.rvalid & s_axi_req.rready;
  wire wr_fire = aw_hold_q & w_hold_q & ~rsp_q.bvalid;
  wire aw_hold_d = aw_take | (aw_hold_q & ~wr_fire);
  wire w_hold_d = w_take | (w_hold_q & ~wr_fire);
  wire bvalid_d = wr_fire | (rsp_q.bvalid & ~b_done);
  wire rvalid_d = ar_take | (rsp_q.rvalid & ~r_done);

  // Write decode
  wire [5:0] widx = awaddr_q[7:2];
  wire wr_stat = (widx == alarm_pkg::IX_STATUS);
  wire wr_rst = (widx == alarm_pkg::IX_RESET);
  wire wr_lim = (widx[5:2] == alarm_pkg::IX_LIMIT[5:2]);
  wire wr_gate = (widx[5:3] == alarm_pkg::IX_GATE[5:3]);
  wire wr_func = (widx[5:2] == alarm_pkg::IX_FUNC[5:2]);
  wire wr_hours = (widx[5:2] == alarm_pkg::IX_HOURS[5:2]);
  wire wr_ok = wr_stat | wr_rst | wr_lim | wr_gate | wr_func | wr_hours;
  wire [3:0] bus_rst = (wr_fire & wr_rst & wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

  // Read decode
  wire [5:0] ridx = s_axi_req.araddr[7:2];
  wire rd_stat = (ridx == alarm_pkg::IX_STATUS);
  wire rd_rst = (ridx == alarm_pkg::IX_RESET);
  wire rd_lim = (ridx[5:2] == alarm_pkg::IX_LIMIT[5:2]);
  wire rd_gate = (ridx[5:3] == alarm_pkg::IX_GATE[5:3]);
  wire rd_func = (ridx[5:2] == alarm_pkg::IX_FUNC[5:2]);
  wire rd_hours = (ridx[5:2] == alarm_pkg::IX_HOURS[5:2]);
  wire rd_ok = rd_stat | rd_rst | rd_lim | rd_gate | rd_func | rd_hours;
  wire [31:0] status_w = {8'h00, act_q, a_q, d_q, z_q, y_q, lim_q};
  wire [31:0] rd_data = rd_stat ? status_w
                      : rd_lim ? lim_cfg_q[ridx[1:0]]
                      : rd_gate ? gate_q[ridx[2:0]]
                      : rd_func ? func_q[ridx[1:0]]
                      : rd_hours ? hours_q[ridx[1:0]]
                      : 32'h0000_0000;

  // Pin events after two-flop synchronisers: 0 tick, 1 panel, 2 din
  wire tick_edge = sync2_q[0] & ~sync3_q[0];
  wire panel_edge = sync2_q[1] & ~sync3_q[1];
  wire din_edge = sync2_q[2] & ~sync3_q[2];
  wire din_lvl = sync2_q[2];

  // Live pool: limits and Y of this pass, other states from the pass start
  wire [31:0] pool_live = {11'h000, din_lvl, snap_q[15:4], y_q, lim_q};
  wire [31:0] pool_prev = {11'h000, din_lvl, snap_q, lim_q};
  wire y_new = gate_eval(gate_q[{1'b0, idx_q}], pool_live,
                         alarm_pkg::L1_MASK);
  wire wd_due = ({{(32 - alarm_pkg::WD_W){1'b0}}, wd_q} >= PASS_MAX_CYC - 1);
  wire pass_go = (st_q == alarm_pkg::ST_IDLE) & (tick_edge | wd_due);

  logic [3:0] z_d;
  logic [3:0] upper_w;
  logic [3:0] rst_take;
  logic [3:0] a_d;
  logic [3:0] inv_w;
  logic [3:0] latch_w;
  logic [3:0] rst_set;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      z_d[i] = gate_eval(gate_q[4 + i], pool_live, alarm_pkg::L2_MASK);
      upper_w[i] = (lim_cfg_q[i].on_thr >= lim_cfg_q[i].off_thr);
      rst_take[i] = rst_pend_q[i] | (func_q[i].rst_state_en
                    & pool_prev[func_q[i].rst_sel]);
      latch_w[i] = func_q[i].latch;
      inv_w[i] = func_q[i].invert;
      a_d[i] = latch_w[i] ? (d_q[i] | (a_q[i] & ~rst_take[i]))
                          : d_q[i];
      rst_set[i] = bus_rst[i] | (panel_edge & func_q[i].rst_panel)
                   | (din_edge & func_q[i].rst_din);
    end
  end

  assign s_axi_rsp = rsp_q;
  assign action = act_q;

  // Bus slave
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_q <= '0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      if (aw_take) awaddr_q <= s_axi_req.awaddr;
      if (w_take) begin
        wdata_q <= s_axi_req.wdata;
        wstrb_q <= s_axi_req.wstrb;
      end
      rsp_q.awready <= ~aw_hold_d & ~bvalid_d;
      rsp_q.wready <= ~w_hold_d & ~bvalid_d;
      rsp_q.bvalid <= bvalid_d;
      if (wr_fire) rsp_q.bresp <= wr_ok ? alarm_pkg::RESP_OKAY
                                        : alarm_pkg::RESP_SLVERR;
      rsp_q.arready <= ~rvalid_d;
      rsp_q.rvalid <= rvalid_d;
      if (ar_take) begin
        rsp_q.rdata <= rd_ok ? rd_data : 32'h0000_0000;
        rsp_q.rresp <= rd_ok ? alarm_pkg::RESP_OKAY : alarm_pkg::RESP_SLVERR;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        lim_cfg_q[i] <= '0;
        func_q[i] <= '0;
      end
      for (int i = 0; i < 8; i++) gate_q[i] <= '0;
    end else if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_lim && widx[1:0] == 2'(i))
          lim_cfg_q[i] <= merge(lim_cfg_q[i], wdata_q, wstrb_q);
        if (wr_func && widx[1:0] == 2'(i))
          func_q[i] <= merge(func_q[i], wdata_q, wstrb_q);
      end
      for (int i = 0; i < 8; i++) begin
        if (wr_gate && widx[2:0] == 3'(i))
          gate_q[i] <= merge(gate_q[i], wdata_q, wstrb_q);
      end
    end
  end

  // Synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {din, panel_reset, cycle_tick};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Pass sequencer; a tick arriving mid-pass is absorbed by that pass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= alarm_pkg::ST_IDLE;
      idx_q <= 2'h0;
      wd_q <= '0;
    end else begin
      wd_q <= pass_go ? '0 : wd_q + alarm_pkg::WD_W'(1);
      unique case (st_q)
        alarm_pkg::ST_IDLE: if (pass_go) st_q <= alarm_pkg::ST_LIM;
        alarm_pkg::ST_LIM: begin
          st_q <= alarm_pkg::ST_Y;
          idx_q <= 2'h0;
        end
        alarm_pkg::ST_Y: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'h3) st_q <= alarm_pkg::ST_Z;
        end
        alarm_pkg::ST_Z: st_q <= alarm_pkg::ST_D;
        alarm_pkg::ST_D: st_q <= alarm_pkg::ST_A;
        alarm_pkg::ST_A: st_q <= alarm_pkg::ST_IDLE;
      endcase
    end
  end

  // Limits and hour counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lim_q <= 4'h0;
      for (int i = 0; i < 4; i++) hours_q[i] <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (st_q == alarm_pkg::ST_LIM) begin
          if (upper_w[i]) begin
            if ($signed(meas.val[i]) > lim_cfg_q[i].on_thr)
              lim_q[i] <= 1'b1;
            else if ($signed(meas.val[i]) < lim_cfg_q[i].off_thr)
              lim_q[i] <= 1'b0;
          end else begin
            if ($signed(meas.val[i]) < lim_cfg_q[i].on_thr)
              lim_q[i] <= 1'b1;
            else if ($signed(meas.val[i]) > lim_cfg_q[i].off_thr)
              lim_q[i] <= 1'b0;
          end
        end
        if (st_q == alarm_pkg::ST_Z && lim_q[i])
          hours_q[i] <= hours_q[i] + 32'h0000_0001;
      end
    end
  end

  // Logic states
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      y_q <= 4'h0;
      z_q <= 4'h0;
      d_q <= 4'h0;
      a_q <= 4'h0;
      act_q <= 4'h0;
      snap_q <= 16'h0000;
      rst_pend_q <= 4'h0;
      for (int i = 0; i < 4; i++) cnt_q[i] <= 8'h00;
    end else begin
      if (st_q == alarm_pkg::ST_LIM) snap_q <= {a_q, d_q, z_q, y_q};
      if (st_q == alarm_pkg::ST_Y) y_q[idx_q] <= y_new;
      if (st_q == alarm_pkg::ST_Z) z_q <= z_d;
      for (int i = 0; i < 4; i++) begin
        if (st_q == alarm_pkg::ST_D) begin
          if (z_q[i] == d_q[i]) begin
            cnt_q[i] <= 8'h00;
          end else if (cnt_q[i] >= (z_q[i] ? func_q[i].on_dly
                                           : func_q[i].off_dly)) begin
            d_q[i] <= z_q[i];
            cnt_q[i] <= 8'h00;
          end else begin
            cnt_q[i] <= cnt_q[i] + 8'h01;
          end
        end
      end
      if (st_q == alarm_pkg::ST_A) begin
        a_q <= a_d;
        act_q <= a_d ^ inv_w;
      end
      // A new request in the consuming cycle survives
      rst_pend_q <= rst_set
                    | (rst_pend_q & {4{st_q != alarm_pkg::ST_A}});
    end
  end

  sequence pass_tail_s;
    st_q == alarm_pkg::ST_Z ##1 st_q == alarm_pkg::ST_D
      ##1 st_q == alarm_pkg::ST_A ##1 st_q == alarm_pkg::ST_IDLE;
  endsequence

  pass_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_Y && idx_q == 2'h3) |=> pass_tail_s)
    else $error("pass stages out of order");

  pass_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    {{(32 - alarm_pkg::WD_W){1'b0}}, wd_q} < PASS_MAX_CYC)
    else $error("evaluation interval too long");

  action_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == alarm_pkg::ST_A |=> act_q == (a_q ^ $past(inv_w)))
    else $error("action state does not match output");

  unlatched_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_A && !latch_w[0]) |=> a_q[0] == $past(d_q[0]))
    else $error("unlatched output does not follow delayed signal");

  latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_A && latch_w[0] && a_q[0] && !rst_take[0])
      |=> a_q[0])
    else $error("latched alarm dropped without reset");

  upper_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_LIM && upper_w[0]
      && $signed(meas.val[0]) > lim_cfg_q[0].on_thr) |=> lim_q[0])
    else $error("upper limit not set");

  lower_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_LIM && !upper_w[3]
      && $signed(meas.val[3]) < lim_cfg_q[3].on_thr) |=> lim_q[3])
    else $error("lower limit not set");

  hours_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_Z && !lim_q[0]) |=> $stable(hours_q[0]))
    else $error("hour counter ran with limit false");

  xor_one_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == alarm_pkg::ST_Y && idx_q == 2'h0
      && gate_q[0].op == alarm_pkg::G_XOR
      && (gate_q[0].en[2:0] & {pool_live[gate_q[0].sel2],
          pool_live[gate_q[0].sel1], pool_live[gate_q[0].sel0]}) == 3'h7)
      |=> !y_q[0])
    else $error("xor true with three inputs set");

endmodule : alarm_logic_evaluator

// [alarm_pkg.sv]
package alarm_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Word indices (byte address = index * 4)
  localparam logic [5:0] IX_STATUS = 6'h00;
  localparam logic [5:0] IX_RESET = 6'h01;
  localparam logic [5:0] IX_LIMIT = 6'h04;
  localparam logic [5:0] IX_GATE = 6'h08;
  localparam logic [5:0] IX_FUNC = 6'h10;
  localparam logic [5:0] IX_HOURS = 6'h14;

  // Positions in the 32-entry input pool
  localparam int P_LIM = 0;
  localparam int P_Y = 4;
  localparam int P_Z = 8;
  localparam int P_D = 12;
  localparam int P_A = 16;
  localparam int P_DIN = 20;

  // Usable gate inputs per level
  localparam logic [3:0] L1_MASK = 4'h7;
  localparam logic [3:0] L2_MASK = 4'hF;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PASS_MAX_NS = 25000000;
  localparam int unsigned PASS_MAX_CYC = PASS_MAX_NS / CLK_PERIOD_NS;
  localparam int WD_W = 20;

  typedef enum logic [2:0] {G_AND, G_OR, G_XOR, G_NAND, G_NOR, G_XNOR} gate_op_t;

  typedef enum logic [2:0] {ST_IDLE, ST_LIM, ST_Y, ST_Z, ST_D, ST_A} pass_st_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic [4:0] sel3;
    logic [4:0] sel2;
    logic [4:0] sel1;
    logic [4:0] sel0;
    logic [3:0] en;
    logic rsv0;
    gate_op_t op;
  } gate_cfg_t;

  typedef struct packed {
    logic [5:0] rsv;
    logic rst_din;
    logic rst_panel;
    logic rst_state_en;
    logic [4:0] rst_sel;
    logic invert;
    logic latch;
    logic [7:0] off_dly;
    logic [7:0] on_dly;
  } func_cfg_t;

  typedef struct packed {
    logic signed [15:0] off_thr;
    logic signed [15:0] on_thr;
  } limit_cfg_t;

  typedef struct packed {
    logic [3:0][15:0] val;
  } meas_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage : alarm_pkg

// [front_end.sv]
`timescale 1ns/1ps
module front_end (
  input wire logic clk,
  input wire logic fire,
  input wire logic [3:0][15:0] vals,
  output alarm_pkg::meas_t meas,
  output logic cycle_tick
);
  logic [2:0] hold_q;
  initial begin
    hold_q = 3'h0;
    meas = '0;
  end
  // Held 4 clocks so the pin synchroniser never misses it
  assign cycle_tick = hold_q != 3'h0;
  always @(posedge clk) begin
    meas.val <= vals;
    if (fire) begin
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
endmodule : front_end

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fire = 1'b0;
  logic panel_reset = 1'b0;
  logic din = 1'b0;
  logic [3:0][15:0] vals = '0;
  alarm_pkg::axi_req_t req = '0;
  alarm_pkg::axi_rsp_t rsp;
  alarm_pkg::meas_t meas;
  alarm_pkg::func_cfg_t f;
  logic cycle_tick;
  logic [3:0] action;
  logic [31:0] rdat;
  logic [31:0] h;
  logic [1:0] rr;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [15:0] hv [8] = '{16'h0078, 16'h0050, 16'h0028, 16'h0050,
                          16'hFFC4, 16'hFFF6, 16'h000A, 16'hFFF6};
  logic [7:0] he = 8'h33;
  logic [3:0][2:0] pats = {3'h0, 3'h1, 3'h3, 3'h7};

  always #25 clk = ~clk;

  front_end u_front_end (.clk(clk), .fire(fire), .vals(vals),
    .meas(meas), .cycle_tick(cycle_tick));
  // Short watchdog keeps the idle wait in the run small
  alarm_logic_evaluator #(.PASS_MAX_CYC(400)) u_alarm_logic_evaluator (
    .clk(clk), .sys_rst(sys_rst), .s_axi_req(req), .s_axi_rsp(rsp),
    .meas(meas), .cycle_tick(cycle_tick), .panel_reset(panel_reset),
    .din(din), .action(action));

  task print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      $display("mismatch at %0t: run too long", $time);
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ad(input logic [5:0] ix, input int k);
    return {ix + 6'(k), 2'b00};
  endfunction : ad

  function automatic logic [31:0] gc(input alarm_pkg::gate_op_t op,
    input logic [3:0] en, input logic [4:0] s0, input logic [4:0] s1,
    input logic [4:0] s2);
    alarm_pkg::gate_cfg_t c;
    c = '0;
    c.op = op;
    c.en = en;
    c.sel0 = s0;
    c.sel1 = s1;
    c.sel2 = s2;
    return c;
  endfunction : gc

  function automatic logic ge(input alarm_pkg::gate_op_t op,
                              input logic [2:0] v);
    case (op)
      alarm_pkg::G_AND: return &v;
      alarm_pkg::G_OR: return |v;
      alarm_pkg::G_XOR: return $countones(v) == 1;
      alarm_pkg::G_NAND: return !(&v);
      alarm_pkg::G_NOR: return !(|v);
      default: return (&v) || !(|v);
    endcase
  endfunction : ge

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha;
    logic hw;
    logic hb;
    int n;
    hb = 1'b0;
    n = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!hb && n < 50) begin
      @(negedge clk);
      ha = req.awvalid && rsp.awready;
      hw = req.wvalid && rsp.wready;
      hb = req.bready && rsp.bvalid;
      rr = rsp.bresp;
      @(posedge clk);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (hb) req.bready <= 1'b0;
      n++;
    end
    chk({31'h0, hb}, 32'h1, "write answer");
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic ha;
    logic hr;
    int n;
    hr = 1'b0;
    n = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!hr && n < 50) begin
      @(negedge clk);
      ha = req.arvalid && rsp.arready;
      hr = req.rready && rsp.rvalid;
      rdat = rsp.rdata;
      rr = rsp.rresp;
      @(posedge clk);
      if (ha) req.arvalid <= 1'b0;
      if (hr) req.rready <= 1'b0;
      n++;
    end
    chk({31'h0, hr}, 32'h1, "read answer");
  endtask : axr

  task automatic pass(input int k);
    repeat (k) begin
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (20) @(posedge clk);
    end
  endtask : pass

  task automatic st(input logic m, input logic e);
    vals[0] <= m ? 16'h0001 : 16'hFFFF;
    pass(1);
    chk({31'h0, action[0]}, {31'h0, e}, "action");
  endtask : st

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    axr(ad(alarm_pkg::IX_STATUS, 0));
    chk(rdat, 32'h0, "status reset");
    chk({28'h0, action}, 32'h0, "action reset");
    axr(8'hFC);
    chk({30'h0, rr}, {30'h0, alarm_pkg::RESP_SLVERR}, "unmapped");
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      if (i == 0) axw(ad(alarm_pkg::IX_LIMIT, 3), 32'h0032_0064);
      if (i == 4) axw(ad(alarm_pkg::IX_LIMIT, 3), 32'h0000_FFCE);
      vals[3] <= hv[i];
      pass(1);
      axr(ad(alarm_pkg::IX_STATUS, 0));
      chk({31'h0, rdat[3]}, {31'h0, he[i]}, "limit");
    end
    $display("test limits done");

    // Limits 0..2 keep equal zero thresholds from reset
    axw(ad(alarm_pkg::IX_GATE, 1),
        gc(alarm_pkg::G_OR, 4'h1, 5'(alarm_pkg::P_Y), 5'h15, 5'h15));
    for (int o = 0; o < 6; o++) begin
      axw(ad(alarm_pkg::IX_GATE, 0),
          gc(alarm_pkg::gate_op_t'(o), 4'h7, 5'h00, 5'h01, 5'h02));
      for (int p = 0; p < 4; p++) begin
        for (int j = 0; j < 3; j++) begin
          vals[j] <= pats[p][j] ? 16'h0001 : 16'hFFFF;
        end
        pass(1);
        axr(ad(alarm_pkg::IX_STATUS, 0));
        chk({31'h0, rdat[4]}, {31'h0, ge(alarm_pkg::gate_op_t'(o),
            pats[p])}, "gate");
        chk({31'h0, rdat[5]}, {31'h0, rdat[4]}, "same pass");
      end
    end
    $display("test gates done");

    // Second AND input points at a zero pool entry but is disabled
    axw(ad(alarm_pkg::IX_GATE, 0),
        gc(alarm_pkg::G_AND, 4'h1, 5'h00, 5'h15, 5'h15));
    axw(ad(alarm_pkg::IX_GATE, 4),
        gc(alarm_pkg::G_OR, 4'h1, 5'(alarm_pkg::P_Y), 5'h15, 5'h15));
    f = '0;
    f.on_dly = 8'h02;
    f.off_dly = 8'h01;
    axw(ad(alarm_pkg::IX_FUNC, 0), f);
    for (int i = 0; i < 5; i++) begin
      st(i < 3, i == 2 || i == 3);
    end
    $display("test delays done");

    f = '0;
    f.latch = 1'b1;
    f.rst_panel = 1'b1;
    axw(ad(alarm_pkg::IX_FUNC, 0), f);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    axw(ad(alarm_pkg::IX_RESET, 0), 32'h1);
    st(1'b0, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    @(posedge clk);
    panel_reset <= 1'b1;
    repeat (4) @(posedge clk);
    panel_reset <= 1'b0;
    st(1'b0, 1'b0);
    f = '0;
    f.invert = 1'b1;
    axw(ad(alarm_pkg::IX_FUNC, 0), f);
    st(1'b0, 1'b1);
    st(1'b1, 1'b0);
    $display("test latch done");

    axr(ad(alarm_pkg::IX_HOURS, 0));
    h = rdat;
    pass(3);
    axr(ad(alarm_pkg::IX_HOURS, 0));
    chk(rdat, h + 32'h3, "hours run");
    vals[0] <= 16'hFFFF;
    pass(1);
    axr(ad(alarm_pkg::IX_HOURS, 0));
    chk(rdat, h + 32'h3, "hours hold");
    vals[0] <= 16'h0001;
    pass(1);
    // No tick: exactly one watchdog pass fits in this wait
    repeat (420) @(posedge clk);
    axr(ad(alarm_pkg::IX_HOURS, 0));
    chk(rdat, h + 32'h5, "watchdog pass");
    $display("test hours done");

    // Four-input AND: din twice, Y0, and limit 0 through the zero select
    f = '0;
    f.latch = 1'b1;
    f.rst_din = 1'b1;
    axw(ad(alarm_pkg::IX_FUNC, 0), f);
    axw(ad(alarm_pkg::IX_GATE, 5), gc(alarm_pkg::G_AND, 4'hF,
        5'(alarm_pkg::P_DIN), 5'(alarm_pkg::P_Y), 5'(alarm_pkg::P_DIN)));
    din <= 1'b1;
    st(1'b1, 1'b1);
    axr(ad(alarm_pkg::IX_STATUS, 0));
    chk({31'h0, rdat[9]}, 32'h1, "four-input and");
    din <= 1'b0;
    st(1'b1, 1'b1);
    axr(ad(alarm_pkg::IX_STATUS, 0));
    chk({31'h0, rdat[9]}, 32'h0, "din level");
    st(1'b0, 1'b1);
    din <= 1'b1;
    st(1'b0, 1'b0);

    // Reset by Z1: its new value acts only from the following pass
    f = '0;
    f.latch = 1'b1;
    f.rst_state_en = 1'b1;
    f.rst_sel = 5'(alarm_pkg::P_Z + 1);
    axw(ad(alarm_pkg::IX_FUNC, 0), f);
    axw(ad(alarm_pkg::IX_GATE, 5),
        gc(alarm_pkg::G_OR, 4'h1, 5'(alarm_pkg::P_DIN), 5'h15, 5'h15));
    din <= 1'b0;
    st(1'b1, 1'b1);
    din <= 1'b1;
    st(1'b0, 1'b1);
    st(1'b0, 1'b0);
    $display("test inputs done");

    // Latched alarm and running hours must all clear on a second reset
    st(1'b1, 1'b1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    axr(ad(alarm_pkg::IX_STATUS, 0));
    chk(rdat, 32'h0, "status restart");
    chk({28'h0, action}, 32'h0, "action restart");
    axr(ad(alarm_pkg::IX_HOURS, 0));
    chk(rdat, 32'h0, "hours restart");
    $display("test restart done");
    print_verdict();
  end
endmodule : testbench
